// file: logic/dma_pkg.sv
// constants, types and helpers shared by the dma controller files
package dma_pkg;

   // ****************************************************************
   // widths
   // ****************************************************************
   localparam int DATA_W    = 8;
   localparam int ADDR_W    = 19;
   localparam int IO_ADDR_W = 16;
   localparam int COUNT_W   = 16;
   localparam int WAIT_W    = 2;
   localparam int BUF_DEPTH = 2;

   // ****************************************************************
   // field positions and codes
   // ****************************************************************
   localparam int SEL_LSB = 16;               // request select field in address bits 17:16
   localparam logic [1:0] SEL_PIN  = 2'h0;
   localparam logic [1:0] SEL_SER0 = 2'h1;
   localparam logic [1:0] SEL_SER1 = 2'h2;
   localparam logic [1:0] MODE_INC = 2'h0;    // address step modes of channel 0 ends
   localparam logic [1:0] MODE_DEC = 2'h1;
   localparam logic [1:0] MODE_FIX = 2'h2;
   localparam logic [1:0] MODE_IO  = 2'h3;
   localparam int CH1_DIR_BIT  = 1;           // 1: i/o to memory
   localparam int CH1_STEP_BIT = 0;           // 1: memory address counts down

   // ****************************************************************
   // load port selects
   // ****************************************************************
   localparam logic [2:0] LD_CH0_SRC   = 3'h0;
   localparam logic [2:0] LD_CH0_DST   = 3'h1;
   localparam logic [2:0] LD_CH1_MEM   = 3'h2;
   localparam logic [2:0] LD_CH1_IO    = 3'h3;
   localparam logic [2:0] LD_CH0_COUNT = 3'h4;
   localparam logic [2:0] LD_CH1_COUNT = 3'h5;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [1:0] RUN_EN_RST    = 2'h0;
   localparam logic       MASTER_EN_RST = 1'b0;

   typedef enum {S_IDLE, S_READ, S_WRITE} phase_t;

   function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a, input logic [1:0] mode);
      unique case (mode)
         MODE_INC: step_addr = a + 19'h1;
         MODE_DEC: step_addr = a - 19'h1;
         default:  step_addr = a;
      endcase
   endfunction : step_addr

endpackage : dma_pkg

// file: logic/pair_buffer.sv
// two-entry valid/ready buffer between the read and write halves of a transfer
`timescale 1ns/1ns
module pair_buffer
   import dma_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic              in_valid,
   output logic                   in_ready,
   input  wire logic [DATA_W-1:0] in_data,
   output logic                   out_valid,
   input  wire logic              out_ready,
   output logic [DATA_W-1:0]      out_data
);
   import dma_pkg::*;

   logic [DATA_W-1:0] mem_q [BUF_DEPTH];
   logic              wr_ptr_q;
   logic              rd_ptr_q;
   logic [1:0]        fill_q;
   logic              push;
   logic              pop;

   assign in_ready  = (fill_q != 2'h2);
   assign out_valid = (fill_q != 2'h0);
   assign out_data  = mem_q[rd_ptr_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         fill_q   <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_q <= ~wr_ptr_q;
         end
         if (pop)
         begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         fill_q <= fill_q + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule : pair_buffer

// file: logic/dual_channel_dma_controller.sv
// two-channel dma engine: request pacing, bus sequencing, termination and abort
// Functional notes
// - serial mode ignores pin, uses serial flags
// - source bits 17:16 pick receive-full request
// - dest bits 17:16 pick transmit-empty request
// - unmasked enable write starts paced transfer
// - channel 1 moves memory and i/o only
// - channel 1 paced by pin, ends count
// - memory strobe or i/o strobe per access
// - i/o ends paced by pin, count flagged
// - programmed waits plus external wait input
// - memory copy ignores pin, runs to zero
// - channel 0 wins simultaneous requests
// - running channel keeps bus while it requests
// - external bus request wins at access boundary
// - suspended transfer resumes, even mid-byte
// - count zero clears enable until rewritten
// - done interrupt is level while disabled
// - nmi clears master enable, suspends both
// - nmi suspends after current access completes
// - re-enable resumes from exact stop point
// - reset stops transfer, keeps address, count
// - sense bit: 0 level, 1 falling edge
// - level request checked once per byte
// - terminal count low in final write
`timescale 1ns/1ns
module dual_channel_dma_controller
   import dma_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    arst_n,
   input  wire logic                    load_strobe,
   input  wire logic [2:0]              load_select,
   input  wire logic [dma_pkg::ADDR_W-1:0] load_value,
   input  wire logic                    status_wr,
   input  wire logic [1:0]              run_enable_wdata,
   input  wire logic                    ch0_run_write_mask_n,
   input  wire logic                    ch1_run_write_mask_n,
   input  wire logic                    master_enable_wdata,
   input  wire logic                    ch0_done_irq_enable,
   input  wire logic                    ch1_done_irq_enable,
   input  wire logic [1:0]              src_mode,
   input  wire logic [1:0]              dest_mode,
   input  wire logic [1:0]              ch1_direction_step_mode,
   input  wire logic                    ch0_request_sense,
   input  wire logic                    ch1_request_sense,
   input  wire logic [dma_pkg::WAIT_W-1:0] io_wait_states,
   input  wire logic [dma_pkg::WAIT_W-1:0] mem_wait_states,
   input  wire logic                    ext_xfer_request_ch0_n,
   input  wire logic                    ext_xfer_request_ch1_n,
   input  wire logic [1:0]              serial_tx_empty_flag,
   input  wire logic [1:0]              serial_rx_full_flag,
   input  wire logic                    nmi_n,
   input  wire logic                    bus_request_in_n,
   input  wire logic                    wait_n,
   input  wire logic [dma_pkg::DATA_W-1:0] rd_data,
   output logic [dma_pkg::ADDR_W-1:0]   bus_address,
   output logic [dma_pkg::DATA_W-1:0]   wr_data,
   output logic                         memory_strobe_n,
   output logic                         io_strobe_n,
   output logic                         write_n,
   output logic                         bus_grant_out_n,
   output logic                         terminal_count_ch0_n,
   output logic                         terminal_count_ch1_n,
   output logic                         ch0_done_irq,
   output logic                         ch1_done_irq,
   output logic                         ch0_run_enable,
   output logic                         ch1_run_enable,
   output logic                         transfer_master_enable,
   output logic [dma_pkg::COUNT_W-1:0]  ch0_byte_count,
   output logic [dma_pkg::COUNT_W-1:0]  ch1_byte_count
);
   import dma_pkg::*;

   // ****************************************************************
   // state
   // ****************************************************************
   logic [ADDR_W-1:0]    src_q, dst_q, mar_q;
   logic [IO_ADDR_W-1:0] iar_q;
   logic [COUNT_W-1:0]   bc0_q, bc1_q;
   phase_t               phase_q;
   logic [1:0]           run_en_q;
   logic                 master_en_q;
   logic                 own_q;
   logic                 pend_write_q;
   logic [WAIT_W-1:0]    wait_cnt_q;
   logic [1:0]           raw_prev_q;
   logic [1:0]           edge_pend_q;
   logic                 nmi_prev_q;
   logic [ADDR_W-1:0]    addr_q;
   logic [DATA_W-1:0]    wr_data_q;
   logic                 mem_n_q, io_n_q, write_n_q, grant_n_q;
   logic [1:0]           tc_n_q;
   logic [1:0]           irq_q;

   // ****************************************************************
   // request pacing
   // ****************************************************************
   function automatic logic serial_flag(input logic [1:0] sel, input logic [1:0] flags);
      unique case (sel)
         SEL_SER0: serial_flag = flags[0];
         SEL_SER1: serial_flag = flags[1];
         default:  serial_flag = 1'b0;     // reserved code never requests
      endcase
   endfunction : serial_flag

   logic [1:0] sel_src, sel_dst;
   logic [1:0] raw_n;
   logic [1:0] sense;
   logic       mem_copy;
   logic [1:0] req;
   logic [1:0] elig;
   logic       pick;
   logic       read_done, write_done, start_read, start_write;
   logic       buf_out_valid;
   logic [DATA_W-1:0] buf_out_data;
   logic       buf_in_ready;
   logic       cur_rd_io, cur_wr_io, nxt_rd_io;

   assign sel_src  = src_q[SEL_LSB+1:SEL_LSB];
   assign sel_dst  = dst_q[SEL_LSB+1:SEL_LSB];
   assign mem_copy = !src_mode[1] && !dest_mode[1];
   assign sense    = {ch1_request_sense, ch0_request_sense};

   always_comb
   begin
      if (sel_src != SEL_PIN)
      begin
         raw_n[0] = !serial_flag(sel_src, serial_rx_full_flag);
      end
      else if (sel_dst != SEL_PIN)
      begin
         raw_n[0] = !serial_flag(sel_dst, serial_tx_empty_flag);
      end
      else
      begin
         raw_n[0] = ext_xfer_request_ch0_n;
      end
      raw_n[1] = ext_xfer_request_ch1_n;
   end

   always_comb
   begin
      for (int c = 0; c < 2; c++)
      begin
         req[c] = sense[c] ? edge_pend_q[c] : !raw_n[c];
      end
      if (mem_copy)
      begin
         req[0] = 1'b1;
      end
      elig = {2{master_en_q}} & run_en_q & req;
      if (own_q && elig[1])
      begin
         pick = 1'b1;
      end
      else
      begin
         pick = !elig[0];
      end
   end

   // edge latch: a fresh edge in the consuming cycle survives
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         raw_prev_q  <= 2'h3;
         edge_pend_q <= 2'h0;
      end
      else
      begin
         raw_prev_q <= raw_n;
         for (int c = 0; c < 2; c++)
         begin
            if (raw_prev_q[c] && !raw_n[c])
            begin
               edge_pend_q[c] <= 1'b1;
            end
            else if (start_read && pick == c[0])
            begin
               edge_pend_q[c] <= 1'b0;
            end
         end
      end
   end

   // ****************************************************************
   // bus sequencing
   // ****************************************************************
   assign cur_rd_io   = own_q ? ch1_direction_step_mode[CH1_DIR_BIT] : (src_mode == MODE_IO);
   assign cur_wr_io   = own_q ? !ch1_direction_step_mode[CH1_DIR_BIT] : (dest_mode == MODE_IO);
   assign nxt_rd_io   = pick ? ch1_direction_step_mode[CH1_DIR_BIT] : (src_mode == MODE_IO);
   assign read_done   = (phase_q == S_READ) && (wait_cnt_q == '0) && wait_n && buf_in_ready;
   assign write_done  = (phase_q == S_WRITE) && (wait_cnt_q == '0) && wait_n;
   assign start_write = (phase_q == S_IDLE) && bus_request_in_n && pend_write_q && buf_out_valid
                        && master_en_q && run_en_q[own_q];
   assign start_read  = (phase_q == S_IDLE) && bus_request_in_n && !pend_write_q && (elig != 2'h0);

   pair_buffer u_buf (
      .clk       (clk),
      .arst_n    (arst_n),
      .in_valid  (read_done),
      .in_ready  (buf_in_ready),
      .in_data   (rd_data),
      .out_valid (buf_out_valid),
      .out_ready (start_write),
      .out_data  (buf_out_data)
   );

   // reset stops the access and empties the buffer, dropping any byte held there
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         phase_q      <= S_IDLE;
         own_q        <= 1'b0;
         pend_write_q <= 1'b0;
         wait_cnt_q   <= '0;
         addr_q       <= '0;
         wr_data_q    <= '0;
         mem_n_q      <= 1'b1;
         io_n_q       <= 1'b1;
         write_n_q    <= 1'b1;
         grant_n_q    <= 1'b1;
         tc_n_q       <= 2'h3;
      end
      else
      begin
         unique case (phase_q)
            S_IDLE:
            begin
               grant_n_q <= bus_request_in_n;
               if (start_read)
               begin
                  phase_q    <= S_READ;
                  own_q      <= pick;
                  addr_q     <= pick ? (nxt_rd_io ? {3'h0, iar_q} : mar_q) : src_q;
                  mem_n_q    <= nxt_rd_io;
                  io_n_q     <= !nxt_rd_io;
                  wait_cnt_q <= nxt_rd_io ? io_wait_states : mem_wait_states;
               end
               else if (start_write)
               begin
                  phase_q    <= S_WRITE;
                  addr_q     <= own_q ? (cur_wr_io ? {3'h0, iar_q} : mar_q) : dst_q;
                  wr_data_q  <= buf_out_data;
                  write_n_q  <= 1'b0;
                  mem_n_q    <= cur_wr_io;
                  io_n_q     <= !cur_wr_io;
                  wait_cnt_q <= cur_wr_io ? io_wait_states : mem_wait_states;
                  tc_n_q[own_q] <= ((own_q ? bc1_q : bc0_q) != 16'h1);
               end
            end
            S_READ, S_WRITE:
            begin
               if (wait_cnt_q != '0)
               begin
                  wait_cnt_q <= wait_cnt_q - 2'h1;
               end
               if (read_done || write_done)
               begin
                  phase_q      <= S_IDLE;
                  pend_write_q <= read_done;
                  mem_n_q      <= 1'b1;
                  io_n_q       <= 1'b1;
                  write_n_q    <= 1'b1;
                  tc_n_q       <= 2'h3;
               end
            end
         endcase
      end
   end

   // ****************************************************************
   // addresses and counts: no reset, contents survive it
   // ****************************************************************
   always_ff @(posedge clk)
   begin
      if (load_strobe)
      begin
         unique case (load_select)
            LD_CH0_SRC:   src_q <= load_value;
            LD_CH0_DST:   dst_q <= load_value;
            LD_CH1_MEM:   mar_q <= load_value;
            LD_CH1_IO:    iar_q <= load_value[IO_ADDR_W-1:0];
            LD_CH0_COUNT: bc0_q <= load_value[COUNT_W-1:0];
            LD_CH1_COUNT: bc1_q <= load_value[COUNT_W-1:0];
            default:      ;
         endcase
      end
      else if (read_done)
      begin
         if (!own_q)
         begin
            src_q <= step_addr(src_q, src_mode);
         end
         else if (!cur_rd_io)
         begin
            mar_q <= step_addr(mar_q, {1'b0, ch1_direction_step_mode[CH1_STEP_BIT]});
         end
      end
      else if (write_done)
      begin
         if (!own_q)
         begin
            dst_q <= step_addr(dst_q, dest_mode);
            bc0_q <= bc0_q - 16'h1;
         end
         else
         begin
            if (!cur_wr_io)
            begin
               mar_q <= step_addr(mar_q, {1'b0, ch1_direction_step_mode[CH1_STEP_BIT]});
            end
            bc1_q <= bc1_q - 16'h1;
         end
      end
   end

   // ****************************************************************
   // enables, abort and termination interrupt
   // ****************************************************************
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         run_en_q <= RUN_EN_RST;
      end
      else
      begin
         if (write_done && ((own_q ? bc1_q : bc0_q) == 16'h1))
         begin
            run_en_q[own_q] <= 1'b0;
         end
         // an unmasked software write of 1 re-arms even in the clearing cycle
         if (status_wr && !ch0_run_write_mask_n)
         begin
            run_en_q[0] <= run_enable_wdata[0];
         end
         if (status_wr && !ch1_run_write_mask_n)
         begin
            run_en_q[1] <= run_enable_wdata[1];
         end
      end
   end

   // nmi beats a software write in the same cycle: it is the abort path
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         master_en_q <= MASTER_EN_RST;
         nmi_prev_q  <= 1'b1;
      end
      else
      begin
         nmi_prev_q <= nmi_n;
         if (nmi_prev_q && !nmi_n)
         begin
            master_en_q <= 1'b0;
         end
         else if (status_wr)
         begin
            master_en_q <= master_enable_wdata;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         irq_q <= 2'h0;
      end
      else
      begin
         irq_q <= ~run_en_q & {ch1_done_irq_enable, ch0_done_irq_enable};
      end
   end

   assign bus_address            = addr_q;
   assign wr_data                = wr_data_q;
   assign memory_strobe_n        = mem_n_q;
   assign io_strobe_n            = io_n_q;
   assign write_n                = write_n_q;
   assign bus_grant_out_n        = grant_n_q;
   assign terminal_count_ch0_n   = tc_n_q[0];
   assign terminal_count_ch1_n   = tc_n_q[1];
   assign ch0_done_irq           = irq_q[0];
   assign ch1_done_irq           = irq_q[1];
   assign ch0_run_enable         = run_en_q[0];
   assign ch1_run_enable         = run_en_q[1];
   assign transfer_master_enable = master_en_q;
   assign ch0_byte_count         = bc0_q;
   assign ch1_byte_count         = bc1_q;

endmodule : dual_channel_dma_controller

// file: tb/dma_bus_properties.sv
// concurrent checks on the dma controller ports
`timescale 1ns/1ns
module dma_bus_properties
   import dma_pkg::*;
(
   input wire logic               clk,
   input wire logic               arst_n,
   input wire logic               nmi_n,
   input wire logic               bus_request_in_n,
   input wire logic               wait_n,
   input wire logic               ch0_done_irq_enable,
   input wire logic               memory_strobe_n,
   input wire logic               io_strobe_n,
   input wire logic               write_n,
   input wire logic               bus_grant_out_n,
   input wire logic               terminal_count_ch0_n,
   input wire logic               ch0_done_irq,
   input wire logic               ch0_run_enable,
   input wire logic               transfer_master_enable,
   input wire logic [COUNT_W-1:0] ch0_byte_count
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   strobe_one_kind_a: assert property (memory_strobe_n || io_strobe_n)
      else $error("both strobes low");
   grant_bus_quiet_a: assert property (!bus_grant_out_n |-> memory_strobe_n && io_strobe_n)
      else $error("access during grant");
   grant_release_a: assert property ($rose(bus_request_in_n) |-> ##[1:2] bus_grant_out_n)
      else $error("grant not returned");
   tc_final_write_a: assert property (!terminal_count_ch0_n |-> !write_n && ch0_byte_count == 16'h1)
      else $error("tc outside last write");
   done_clears_en_a: assert property ($rose(terminal_count_ch0_n) |-> ##[0:1] !ch0_run_enable)
      else $error("enable kept after end");
   irq_level_a: assert property ($past(arst_n) |-> ch0_done_irq == $past(!ch0_run_enable && ch0_done_irq_enable))
      else $error("irq level wrong");
   nmi_master_a: assert property ($fell(nmi_n) |-> ##[1:3] !transfer_master_enable)
      else $error("nmi kept master on");
   off_stays_quiet_a: assert property (!transfer_master_enable && memory_strobe_n && io_strobe_n
      |=> memory_strobe_n && io_strobe_n)
      else $error("access while off");
   wait_stretch_a: assert property (!memory_strobe_n && !wait_n |=> !memory_strobe_n)
      else $error("wait input ignored");
endmodule : dma_bus_properties

bind dual_channel_dma_controller dma_bus_properties dma_bus_properties_i (.*);

// file: tb/bus_space_model.sv
// memory and i/o space answering the dma engine's bus cycles
`timescale 1ns/1ns
module bus_space_model
   import dma_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              slow,
   input  wire logic [ADDR_W-1:0] bus_address,
   input  wire logic              memory_strobe_n,
   input  wire logic              io_strobe_n,
   input  wire logic              write_n,
   input  wire logic [DATA_W-1:0] wr_data,
   output logic [DATA_W-1:0]      rd_data,
   output logic                   wait_n
);
   logic [DATA_W-1:0] mem [256];
   logic [DATA_W-1:0] last_q;
   logic              act_q;
   wire               act = !memory_strobe_n || !io_strobe_n;
   // idle bus toggles so a sample one cycle late can never match by luck
   assign rd_data = (act && write_n) ? (bus_address[7:0] ^ 8'h5A) : ~last_q;
   assign wait_n  = !(slow && act && !act_q);
   always @(posedge clk)
   begin
      act_q  <= act;
      last_q <= rd_data;
      if (act && !write_n)
         mem[bus_address[7:0]] <= wr_data;
   end
endmodule : bus_space_model

// file: tb/dual_channel_dma_controller_test.sv
// self-checking bench for the dual-channel dma controller
`timescale 1ns/1ns
module dual_channel_dma_controller_test;
   import dma_pkg::*;
   logic clk, arst_n, load_strobe, status_wr, ch0_run_write_mask_n, ch1_run_write_mask_n;
   logic master_enable_wdata, ch0_done_irq_enable, ch1_done_irq_enable, ch0_request_sense;
   logic ch1_request_sense, nmi_n, ext_xfer_request_ch0_n, ext_xfer_request_ch1_n;
   logic bus_request_in_n, wait_n, slow, tc0, tc1, io_seen, fa_arm;
   logic [2:0]         load_select;
   logic [1:0]         run_enable_wdata, src_mode, dest_mode, ch1_direction_step_mode;
   logic [1:0]         serial_tx_empty_flag, serial_rx_full_flag;
   logic [WAIT_W-1:0]  io_wait_states, mem_wait_states;
   logic [ADDR_W-1:0]  load_value, bus_address, fa;
   logic [DATA_W-1:0]  rd_data, wr_data;
   logic memory_strobe_n, io_strobe_n, write_n, bus_grant_out_n, terminal_count_ch0_n;
   logic terminal_count_ch1_n, ch0_done_irq, ch1_done_irq, ch0_run_enable, ch1_run_enable;
   logic transfer_master_enable;
   logic [COUNT_W-1:0] ch0_byte_count, ch1_byte_count, c;
   int                 error_cnt, n_checks, cyc;

   dual_channel_dma_controller dual_channel_dma_controller_i (.*);
   bus_space_model bus_space_model_i (.*);

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic tick(int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : finish_test

   task automatic chk(string nm, logic [31:0] exp, got);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic load(logic [2:0] s, logic [ADDR_W-1:0] v);
      {load_select, load_value, load_strobe} = {s, v, 1'b1};
      tick();
      load_strobe = 1'b0;
      tick();
   endtask : load

   task automatic go(logic [1:0] en, logic m0_n, m1_n);
      run_enable_wdata     = en;
      ch0_run_write_mask_n = m0_n;
      ch1_run_write_mask_n = m1_n;
      master_enable_wdata  = 1'b1;
      status_wr            = 1'b1;
      tick();
      {status_wr, ch0_run_write_mask_n, ch1_run_write_mask_n} = 3'h3;
   endtask : go

   task automatic copy0(logic [ADDR_W-1:0] s, d, n);
      src_mode  = MODE_INC;
      dest_mode = MODE_INC;
      load(LD_CH0_SRC, s);
      load(LD_CH0_DST, d);
      load(LD_CH0_COUNT, n);
      go(2'h1, 1'b0, 1'b1);
   endtask : copy0

   task automatic wait_done();
      for (int i = 0; i < 2000 && (ch0_run_enable || ch1_run_enable); i++)
         tick();
      chk("run enables", 0, {ch0_run_enable, ch1_run_enable});
      tick();
   endtask : wait_done

   task automatic chkmem(logic [7:0] d, s, st, int n);
      for (int i = 0; i < n; i++)
         chk("memory", (s + st * i) ^ 8'h5A, bus_space_model_i.mem[8'(d + i)]);
   endtask : chkmem

   always @(negedge clk)
   begin
      cyc++;
      tc0 |= !terminal_count_ch0_n;
      tc1 |= !terminal_count_ch1_n;
      io_seen |= !io_strobe_n;
      if (fa_arm && !(memory_strobe_n && io_strobe_n))
      begin
         fa     = bus_address;
         fa_arm = 1'b0;
      end
      if (cyc > 20000)
      begin
         error_cnt++;
         finish_test();
      end
   end

   // ****************************************************************
   // scenarios
   // ****************************************************************
   initial
   begin
      {arst_n, load_strobe, status_wr, run_enable_wdata, master_enable_wdata, fa_arm, load_select, load_value} = 0;
      {ch0_done_irq_enable, ch1_done_irq_enable, ch0_request_sense, ch1_request_sense, io_wait_states} = 0;
      {src_mode, dest_mode, ch1_direction_step_mode, serial_tx_empty_flag, serial_rx_full_flag, mem_wait_states} = 0;
      {ch0_run_write_mask_n, ch1_run_write_mask_n, nmi_n, bus_request_in_n} = 4'hF;
      {ext_xfer_request_ch0_n, ext_xfer_request_ch1_n, slow, tc0, tc1, io_seen} = 6'h30;
      tick(12);
      arst_n = 1'b1;
      // slow memory copy with programmed and external waits
      {mem_wait_states, slow, ch0_done_irq_enable} = 4'h7;
      copy0(19'h00020, 19'h00040, 19'h3);
      wait_done();
      chkmem(8'h40, 8'h20, 8'h1, 3);
      chk("ch0 count", 0, ch0_byte_count);
      chk("ch0 irq", 1, ch0_done_irq);
      chk("tc0 seen", 1, tc0);
      ch0_done_irq_enable = 1'b0;
      tick(2);
      chk("ch0 irq off", 0, ch0_done_irq);
      // external master takes the bus mid-transfer
      copy0(19'h00060, 19'h00080, 19'h4);
      tick(3);
      bus_request_in_n = 1'b0;
      for (int i = 0; i < 20 && bus_grant_out_n; i++)
         tick();
      c = ch0_byte_count;
      tick(10);
      chk("grant", 0, bus_grant_out_n);
      chk("count held", c, ch0_byte_count);
      bus_request_in_n = 1'b1;
      wait_done();
      chkmem(8'h80, 8'h60, 8'h1, 4);
      // nmi abort then resume
      copy0(19'h000A0, 19'h000C0, 19'h8);
      tick(6);
      nmi_n = 1'b0;
      tick();
      nmi_n = 1'b1;
      tick(6);
      c = ch0_byte_count;
      tick(10);
      chk("master off", 0, transfer_master_enable);
      chk("frozen count", c, ch0_byte_count);
      go(2'h1, 1'b0, 1'b1);
      wait_done();
      chkmem(8'hC0, 8'hA0, 8'h1, 8);
      // channel 1 i/o to memory, level paced
      load(LD_CH1_MEM, 19'h000E0);
      load(LD_CH1_IO, 19'h00033);
      load(LD_CH1_COUNT, 19'h2);
      {ch1_direction_step_mode, io_wait_states} = 4'hA;
      go(2'h2, 1'b1, 1'b0);
      tick(20);
      chk("ch1 waits", 2, ch1_byte_count);
      ext_xfer_request_ch1_n = 1'b0;
      wait_done();
      ext_xfer_request_ch1_n = 1'b1;
      chkmem(8'hE0, 8'h33, 8'h0, 2);
      chk("tc1 io irq1", 3'h6, {tc1, io_seen, ch1_done_irq});
      // serial-flag pacing; code 3 must stay quiet
      ch0_request_sense      = 1'b1;
      for (int s = 1; s < 4; s++)
      begin
         {src_mode, dest_mode} = {MODE_IO, MODE_INC};
         load(LD_CH0_SRC, (19'(s) << SEL_LSB) | 19'h6);
         ext_xfer_request_ch0_n = 1'b0;
         load(LD_CH0_DST, 19'h10 * 19'(s));
         load(LD_CH0_COUNT, 19'h2);
         go(2'h1, 1'b0, 1'b1);
         tick(15);
         chk("serial idle", 2, ch0_byte_count);
         repeat (2)
         begin
            serial_rx_full_flag = 2'(s);
            tick(8);
            serial_rx_full_flag = 2'h0;
            tick(8);
         end
         chk("serial count", (s == 3) ? 2 : 0, ch0_byte_count);
      end
      go(2'h0, 1'b0, 1'b1);
      ext_xfer_request_ch0_n = 1'b1;
      // both channels asked at once
      load(LD_CH1_MEM, 19'h000F0);
      load(LD_CH1_COUNT, 19'h1);
      src_mode  = MODE_INC;
      load(LD_CH0_SRC, 19'h00050);
      load(LD_CH0_COUNT, 19'h2);
      ext_xfer_request_ch1_n = 1'b0;
      fa_arm = 1'b1;
      go(2'h3, 1'b0, 1'b0);
      wait_done();
      ext_xfer_request_ch1_n = 1'b1;
      chk("first address", 19'h00050, fa);
      chkmem(8'hF0, 8'h33, 8'h0, 1);
      // reset keeps counts, clears control
      load(LD_CH0_COUNT, 19'h5);
      arst_n = 1'b0;
      tick(2);
      arst_n = 1'b1;
      tick();
      chk("count kept", 5, ch0_byte_count);
      chk("master reset", 0, transfer_master_enable);
      finish_test();
   end
endmodule : dual_channel_dma_controller_test
